// >>> stc_pkg.sv
/*
  Shared types and constants for the two 16-bit timer units.
  Assumes a single synchronous clock domain and no software bus:
  per-channel configuration arrives as plain static inputs.
*/
`default_nettype none

package stc_pkg;

  // ***************************************************************
  // Sizes and reset values
  // ***************************************************************
  localparam int          CNT_W       = 16;
  localparam int          UNIT0_CH    = 4;
  localparam int          UNIT1_CH    = 8;
  localparam logic [15:0] CNT_RST     = 16'h0000;
  localparam logic [15:0] CNT_ONE     = 16'h0001;

  // ***************************************************************
  // Channel modes and edge choices
  // ***************************************************************
  typedef enum logic [2:0] {
    STC_MODE_INTERVAL  = 3'b000,
    STC_MODE_SQUARE    = 3'b001,
    STC_MODE_EVENT     = 3'b010,
    STC_MODE_DIVIDER   = 3'b011,
    STC_MODE_PULSE_INT = 3'b100,
    STC_MODE_LEVEL_WID = 3'b101,
    STC_MODE_DELAY     = 3'b110,
    STC_MODE_SLAVE_PWM = 3'b111
  } stc_mode_t;

  typedef enum logic [1:0] {
    STC_EDGE_FALL = 2'b00,
    STC_EDGE_RISE = 2'b01,
    STC_EDGE_BOTH = 2'b10
  } stc_edge_t;

  typedef struct packed {
    logic             enable;
    stc_mode_t        mode;
    stc_edge_t        edge_sel;
    logic [15:0]      period;
  } stc_cfg_t;

endpackage

`default_nettype wire

// >>> stc_timer_units.sv
/*
  Two timer units of 16-bit channels (four, then eight), every channel
  independently configured from static input ports.
  Assumes count_input_pin_in is synchronous to clk_in and that the
  configuration of a channel changes only while it is disabled.
*/
// Overview of operation
// - There are two units, the first with four and the second with eight 16-bit channels.
// - Each channel runs its own mode regardless of its neighbours, except a slave PWM channel, which follows the events of its unit's first channel.
// - Interval mode raises the channel event repeatedly, once every programmed period plus one clock cycles.
// - Square-wave mode toggles the output at every channel event for an even duty cycle.
// - Event-counter mode counts valid input edges and raises the event on the edge after the programmed number.
// - Only channel zero of the first unit divides its input clock and drives the result out.
// - Pulse-interval mode starts on a valid edge and captures the count at the next valid edge.
// - Level-width mode starts on one edge and captures the count on the opposite edge.
// - Delay mode starts on a valid edge and raises the event once the programmed delay elapses.
// - In linked use the first channel of a unit sets the period and slaves follow it as PWM.
`timescale 1ns/1ps
`default_nettype none

module stc_timer_units #(
  parameter int N0 = stc_pkg::UNIT0_CH,
  parameter int N1 = stc_pkg::UNIT1_CH
) (
  input  wire logic                              clk_in,
  input  wire logic                              rst_n_in,
  input  wire stc_pkg::stc_cfg_t [N0+N1-1:0]     cfg_in,
  input  wire logic [N0+N1-1:0]                  count_input_pin_in,
  output logic [N0+N1-1:0]                       channel_event_irq_out,
  output logic [N0+N1-1:0]                       wave_output_pin_out,
  output logic [N0+N1-1:0][stc_pkg::CNT_W-1:0]   capture_out
);

  localparam int NCH = N0 + N1;

  logic [NCH-1:0] irq_vec;

  // ***************************************************************
  // Per-channel counters, one copy per channel
  // ***************************************************************
  genvar g;
  generate
    for (g = 0; g < NCH; g++)
    begin : g_ch
      localparam int  MASTER = (g < N0) ? 0 : N0;
      localparam bit  IS_DIV = (g == 0);
      localparam bit  IS_SLV = (g != MASTER);

      logic [15:0]    cnt_ff;
      logic [15:0]    nxt_cnt;
      logic [15:0]    cap_ff;
      logic [15:0]    nxt_cap;
      logic           run_ff;
      logic           nxt_run;
      logic           wave_ff;
      logic           nxt_wave;
      logic           irq_ff;
      logic           nxt_irq;
      logic           prev_ff;

      wire stc_pkg::stc_cfg_t cfg     = cfg_in[g];
      wire logic      pin_w   = count_input_pin_in[g];
      wire logic      rise_w  = pin_w & ~prev_ff;
      wire logic      fall_w  = ~pin_w & prev_ff;
      wire logic      hit_w   = (cfg.edge_sel == stc_pkg::STC_EDGE_RISE) ? rise_w :
                                (cfg.edge_sel == stc_pkg::STC_EDGE_FALL) ? fall_w :
                                (rise_w | fall_w);
      // Level width: both-edge choice measures the high level
      wire logic      start_w = (cfg.edge_sel == stc_pkg::STC_EDGE_FALL) ? fall_w : rise_w;
      wire logic      stop_w  = (cfg.edge_sel == stc_pkg::STC_EDGE_FALL) ? rise_w : fall_w;
      wire logic      zero_w  = (cnt_ff == stc_pkg::CNT_RST);
      wire logic [15:0] cnt_dn = cnt_ff - stc_pkg::CNT_ONE;
      wire logic [15:0] cnt_up = cnt_ff + stc_pkg::CNT_ONE;
      wire logic      mst_tc  = irq_vec[MASTER];

      always_comb
      begin
        nxt_cnt  = cnt_ff;
        nxt_cap  = cap_ff;
        nxt_run  = run_ff;
        nxt_wave = wave_ff;
        nxt_irq  = 1'b0;
        if (!cfg.enable)
        begin
          // Idle channels preload so the first period is exact
          nxt_cnt  = cfg.period;
          nxt_run  = 1'b0;
          nxt_wave = 1'b0;
        end
        else
        begin
          unique case (cfg.mode)
            stc_pkg::STC_MODE_INTERVAL,
            stc_pkg::STC_MODE_SQUARE:
            begin
              if (zero_w)
              begin
                nxt_cnt = cfg.period;
                nxt_irq = 1'b1;
                if (cfg.mode == stc_pkg::STC_MODE_SQUARE)
                  nxt_wave = ~wave_ff;
              end
              else
                nxt_cnt = cnt_dn;
            end
            stc_pkg::STC_MODE_EVENT,
            stc_pkg::STC_MODE_DIVIDER:
            begin
              // Divider falls back to idle on any channel but channel zero of the first unit
              if (hit_w && (IS_DIV || cfg.mode == stc_pkg::STC_MODE_EVENT))
              begin
                if (zero_w)
                begin
                  nxt_cnt = cfg.period;
                  nxt_irq = 1'b1;
                  if (cfg.mode == stc_pkg::STC_MODE_DIVIDER)
                    nxt_wave = ~wave_ff;
                end
                else
                  nxt_cnt = cnt_dn;
              end
            end
            stc_pkg::STC_MODE_PULSE_INT:
            begin
              if (hit_w)
              begin
                if (run_ff)
                begin
                  nxt_cap = cnt_ff;
                  nxt_irq = 1'b1;
                end
                nxt_run = 1'b1;
                nxt_cnt = stc_pkg::CNT_RST;
              end
              else if (run_ff)
                nxt_cnt = cnt_up; // Wraps past 16'hFFFF, no overflow flag
            end
            stc_pkg::STC_MODE_LEVEL_WID:
            begin
              if (!run_ff)
              begin
                if (start_w)
                begin
                  nxt_run = 1'b1;
                  nxt_cnt = stc_pkg::CNT_RST;
                end
              end
              else if (stop_w)
              begin
                nxt_cap = cnt_ff;
                nxt_irq = 1'b1;
                nxt_run = 1'b0;
              end
              else
                nxt_cnt = cnt_up;
            end
            stc_pkg::STC_MODE_DELAY:
            begin
              if (!run_ff)
              begin
                if (hit_w)
                begin
                  nxt_run = 1'b1;
                  nxt_cnt = cfg.period;
                end
              end
              else if (zero_w)
              begin
                nxt_irq = 1'b1;
                nxt_run = 1'b0;
              end
              else
                nxt_cnt = cnt_dn;
            end
            stc_pkg::STC_MODE_SLAVE_PWM:
            begin
              // Master restart opens the pulse, slave count closes it
              if (IS_SLV && mst_tc)
              begin
                nxt_cnt  = cfg.period;
                nxt_wave = (cfg.period != stc_pkg::CNT_RST);
              end
              else if (IS_SLV && zero_w)
              begin
                if (wave_ff)
                  nxt_irq = 1'b1;
                nxt_wave = 1'b0;
              end
              else if (IS_SLV)
                nxt_cnt = cnt_dn;
            end
          endcase
        end
      end

      always_ff @(posedge clk_in)
      begin
        if (!rst_n_in)
        begin
          cnt_ff  <= stc_pkg::CNT_RST;
          cap_ff  <= stc_pkg::CNT_RST;
          run_ff  <= 1'b0;
          wave_ff <= 1'b0;
          irq_ff  <= 1'b0;
          prev_ff <= 1'b0;
        end
        else
        begin
          cnt_ff  <= nxt_cnt;
          cap_ff  <= nxt_cap;
          run_ff  <= nxt_run;
          wave_ff <= nxt_wave;
          irq_ff  <= nxt_irq;
          prev_ff <= pin_w;
        end
      end

      assign irq_vec[g]               = irq_ff;
      assign channel_event_irq_out[g] = irq_ff;
      assign wave_output_pin_out[g]   = wave_ff;
      assign capture_out[g]           = cap_ff;
    end
  endgenerate

endmodule // stc_timer_units

`default_nettype wire

// >>> stc_timer_units_assertions.sv
/* Concurrent checks on the ports of stc_timer_units.
   Assumes the bench sets the channel configurations used here. */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Port checker
// ****************************************
module stc_timer_units_chk #(
  parameter int N0 = stc_pkg::UNIT0_CH,
  parameter int N1 = stc_pkg::UNIT1_CH
) (
  input wire logic                            clk_in,
  input wire logic                            rst_n_in,
  input wire stc_pkg::stc_cfg_t [N0+N1-1:0]   cfg_in,
  input wire logic [N0+N1-1:0]                count_input_pin_in,
  input wire logic [N0+N1-1:0]                channel_event_irq_out,
  input wire logic [N0+N1-1:0]                wave_output_pin_out,
  input wire logic [N0+N1-1:0][15:0]          capture_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  chk_reset_clears_out: assert property (disable iff (1'b0) !rst_n_in |=>
    !(|channel_event_irq_out) && !(|wave_output_pin_out)) else $error("outputs not cleared by reset");
  chk_interval_gap: assert property (disable iff (!rst_n_in || !cfg_in[0].enable)
    channel_event_irq_out[0] && cfg_in[0].mode == stc_pkg::STC_MODE_INTERVAL && cfg_in[0].period == 16'h0003
    |=> !channel_event_irq_out[0] [*3]) else $error("interval event too soon");
  chk_square_half: assert property (disable iff (!rst_n_in || !cfg_in[5].enable)
    $changed(wave_output_pin_out[5]) && cfg_in[5].mode == stc_pkg::STC_MODE_SQUARE && cfg_in[5].period == 16'h0003
    |=> $stable(wave_output_pin_out[5]) [*3]) else $error("square half too short");
  chk_off_quiet: assert property (!cfg_in[7].enable && !$past(cfg_in[7].enable)
    |-> !channel_event_irq_out[7] && !wave_output_pin_out[7]) else $error("disabled channel active");
  chk_div_refused: assert property (cfg_in[1].mode == stc_pkg::STC_MODE_DIVIDER
    |-> !wave_output_pin_out[1] && !channel_event_irq_out[1]) else $error("divider on wrong channel");
  chk_master_refused: assert property (cfg_in[4].mode == stc_pkg::STC_MODE_SLAVE_PWM
    |-> !wave_output_pin_out[4] && !channel_event_irq_out[4]) else $error("slave mode on master");
  chk_capture_event: assert property ($past(rst_n_in) && $changed(capture_out[2])
    |-> ##[0:1] channel_event_irq_out[2]) else $error("capture without event");
  chk_pwm_width: assert property (disable iff (!rst_n_in || !cfg_in[8].enable)
    $rose(wave_output_pin_out[8]) && cfg_in[8].mode == stc_pkg::STC_MODE_SLAVE_PWM && cfg_in[8].period == 16'h0002
    |-> wave_output_pin_out[8] [*3] ##1 !wave_output_pin_out[8]) else $error("pwm pulse width wrong");
endmodule // stc_timer_units_chk
bind stc_timer_units stc_timer_units_chk #(.N0(N0), .N1(N1)) u_chk (.clk_in, .rst_n_in, .cfg_in,
  .count_input_pin_in, .channel_event_irq_out, .wave_output_pin_out, .capture_out);
`default_nettype wire

// >>> stc_pin_src.sv
/* Free-running pulse source on count input pins.
   Assumes the clock of the timer units; held low while run is low. */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Pulse source
// ****************************************
module stc_pin_src #(
  parameter int HALF = 3
) (
  input  wire logic clk_in,
  input  wire logic run_in,
  output logic      pin_out
);
  logic [7:0] cnt_ff;
  wire        tick = (cnt_ff == 8'(HALF - 1));
  // Low outside run, so no stray edge reaches a channel at start
  always_ff @(posedge clk_in)
  begin
    cnt_ff  <= (!run_in || tick) ? 8'h00 : cnt_ff + 8'h01;
    pin_out <= run_in & (pin_out ^ tick);
  end
endmodule // stc_pin_src
`default_nettype wire

// >>> test_sixteen_bit_timer_channels.sv
/* Self-checking bench for stc_timer_units.
   Assumes the package, design, checker and pulse source compile first. */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Bench
// ****************************************
module test_sixteen_bit_timer_channels;
  localparam int NC = 12;
  logic                        clk_in = 1'b0;
  logic                        rst_n_in = 1'b0;
  stc_pkg::stc_cfg_t [NC-1:0]  cfg = '0;
  logic [NC-1:0]               pin = '0;
  logic                        src;
  logic [NC-1:0]               irq, wave, wv_q;
  logic [NC-1:0][15:0]         cap;
  int                          irq_cnt [NC], tog_cnt [NC], ib [NC], tb0 [NC];
  int                          err_count = 0, cmp_count = 0, cyc = 0;
  always #12.5 clk_in = ~clk_in;
  stc_pin_src u_src (.clk_in(clk_in), .run_in(rst_n_in), .pin_out(src));
  stc_timer_units dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .cfg_in(cfg),
    .count_input_pin_in({pin[11:3], src, src, src}), .channel_event_irq_out(irq),
    .wave_output_pin_out(wave), .capture_out(cap));
  // Counted on the falling edge, away from where stimulus changes
  always @(negedge clk_in)
  begin
    cyc++;
    for (int k = 0; k < NC; k++)
    begin
      if (irq[k] === 1'b1) irq_cnt[k]++;
      if (wave[k] !== wv_q[k]) tog_cnt[k]++;
    end
    wv_q = wave;
    if (cyc == 3000)
    begin
      err_count++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e)
    begin
      err_count++;
      $display("BAD %s expected %0d seen %0d", n, e, g);
    end
  endtask
  function automatic logic [15:0] di(input int k); return 16'(irq_cnt[k] - ib[k]); endfunction
  function automatic logic [15:0] dt(input int k); return 16'(tog_cnt[k] - tb0[k]); endfunction
  // Config written while disabled, enable raised one edge later
  task automatic set_ch(input int k, input logic [2:0] m, input logic [15:0] p,
                        input stc_pkg::stc_edge_t e = stc_pkg::STC_EDGE_RISE);
    @(posedge clk_in);
    cfg[k] <= '{1'b0, stc_pkg::stc_mode_t'(m), e, p};
    @(posedge clk_in);
    cfg[k].enable <= 1'b1;
  endtask
  task automatic win(input int warm, input int len);
    repeat (warm) @(posedge clk_in);
    ib = irq_cnt;
    tb0 = tog_cnt;
    repeat (len) @(posedge clk_in);
  endtask
  task automatic pulse(input int k, input int hi);
    @(posedge clk_in);
    pin[k] <= 1'b1;
    repeat (hi) @(posedge clk_in);
    pin[k] <= 1'b0;
    repeat (3) @(posedge clk_in);
  endtask
  task automatic done(input string n);
    @(posedge clk_in);
    cfg <= '0;
    $display("Test %s finished", n);
  endtask
  task automatic t_interval();
    set_ch(0, 3'h0, 16'h0003);
    set_ch(5, 3'h1, 16'h0003);
    win(8, 40);
    cmp("irq ch0", 16'h000A, di(0));
    cmp("toggles ch5", 16'h000A, dt(5));
    done("interval");
  endtask
  task automatic t_event();
    set_ch(6, 3'h2, 16'h0002);
    win(2, 0);
    pulse(6, 2);
    pulse(6, 2);
    cmp("early irq ch6", 16'h0000, di(6));
    pulse(6, 2);
    cmp("irq ch6", 16'h0001, di(6));
    done("event");
  endtask
  // Divider, refused modes and pulse interval side by side
  task automatic t_divider();
    set_ch(0, 3'h3, 16'h0000);
    set_ch(1, 3'h3, 16'h0000);
    set_ch(2, 3'h4, 16'h0000);
    set_ch(4, 3'h7, 16'h0003);
    win(12, 60);
    cmp("div toggles ch0", 16'h000A, dt(0));
    cmp("div toggles ch1", 16'h0000, dt(1));
    cmp("irq ch4", 16'h0000, di(4));
    cmp("interval ch2", 16'h0005, cap[2]);
    cmp("irq ch2", 16'h000A, di(2));
    done("divider");
  endtask
  task automatic t_width();
    set_ch(3, 3'h5, 16'h0000);
    set_ch(7, 3'h6, 16'h0005);
    win(2, 0);
    pulse(3, 7);
    cmp("width ch3", 16'h0006, cap[3]);
    cmp("irq ch3", 16'h0001, di(3));
    pin[7] <= 1'b1;
    repeat (4) @(posedge clk_in);
    cmp("early irq ch7", 16'h0000, di(7));
    repeat (12) @(posedge clk_in);
    cmp("irq ch7", 16'h0001, di(7));
    done("width");
  endtask
  task automatic t_pwm();
    set_ch(4, 3'h0, 16'h0007);
    set_ch(8, 3'h7, 16'h0002);
    win(16, 64);
    cmp("pwm toggles ch8", 16'h0010, dt(8));
    cmp("irq ch8", 16'h0008, di(8));
    done("pwm");
  endtask
  // Both-edge counting and low-level width
  task automatic t_edges();
    set_ch(9, 3'h2, 16'h0003, stc_pkg::STC_EDGE_BOTH);
    set_ch(10, 3'h5, 16'h0000, stc_pkg::STC_EDGE_FALL);
    win(2, 0);
    pulse(9, 2);
    cmp("early irq ch9", 16'h0000, di(9));
    pulse(9, 2);
    cmp("irq ch9", 16'h0001, di(9));
    @(posedge clk_in);
    pin[10] <= 1'b1;
    repeat (2) @(posedge clk_in);
    pin[10] <= 1'b0;
    repeat (4) @(posedge clk_in);
    pin[10] <= 1'b1;
    repeat (3) @(posedge clk_in);
    cmp("low width ch10", 16'h0003, cap[10]);
    cmp("irq ch10", 16'h0001, di(10));
    done("edges");
  endtask
  initial
  begin
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_interval();
    t_event();
    t_divider();
    t_width();
    t_pwm();
    t_edges();
    print_verdict();
  end
endmodule // test_sixteen_bit_timer_channels
`default_nettype wire
